// *** core/dacc_pkg.sv ***
// constants shared by the converter control block
package dacc_pkg;
  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [7:0] DACC_CTRL_IDX = 8'h00;
  localparam logic [7:0] DACC_DATA_IDX = 8'h01;
  localparam logic [11:0] DACC_CTRL_ADDR = 12'h000;
  localparam logic [11:0] DACC_DATA_ADDR = 12'h004;
  localparam int DACC_ENABLE_BIT = 0;
  localparam int DACC_OUTPUT_BUFFER_ENABLE_BIT = 6;
  localparam int DACC_RUN_IN_STANDBY_BIT = 7;
  localparam logic [7:0] DACC_CTRL_MASK = 8'hc1;
  localparam logic [7:0] DACC_CTRL_RESET = 8'h00;
  localparam logic [7:0] DACC_DATA_RESET = 8'h00;
  localparam logic [31:0] DACC_ZERO_WORD = 32'h0000_0000;
  // ****************************************
  // timing
  // ****************************************
  localparam int DACC_CLK_MHZ = 25;
  localparam int DACC_STARTUP_NS = 1000;
  localparam int DACC_STARTUP_CYC =
    (DACC_STARTUP_NS * DACC_CLK_MHZ + 999) / 1000;
  // ****************************************
  // sleep mode encoding
  // ****************************************
  localparam logic [1:0] DACC_SLEEP_ACTIVE = 2'h0;
  localparam logic [1:0] DACC_SLEEP_IDLE = 2'h1;
  localparam logic [1:0] DACC_SLEEP_STANDBY = 2'h2;
  localparam logic [1:0] DACC_SLEEP_PDOWN = 2'h3;
  // converter power state, one-hot
  typedef enum logic [2:0] {
    DACC_OFF = 3'b001,
    DACC_START = 3'b010,
    DACC_RUN = 3'b100
  } dacc_state_t;
endpackage

// *** core/dacc_top.sv ***
// control wrapper for an 8-bit digital-to-analog converter
// How it works
// RULE1: control bit 0 written one powers the converter, zero powers it off
// RULE2: while enabled, each data write starts a fresh conversion at once
// RULE3: while disabled, data writes only store; enabling converts the value
// RULE4: control bit 6 turns on the output buffer and routes out to pin
// RULE5: when enabled, output goes to comparator and converter regardless
// RULE6: run-in-standby bit 7 keeps converter and buffer alive in standby
// RULE7: with bit 7 clear, standby stops conversion and powers both down
// RULE8: on leaving standby re-enable, wait start-up time, then convert
// RULE9: power-down sleep always turns off converter and buffer
// RULE10: data register is 8-bit read/write at index 0x01, reset 0x00
// RULE11: software picks reference, output use, data, then sets enable
// RULE12: debug halt leaves the converter and its registers untouched
// RULE13: control bits 5 to 1 read zero and ignore writes
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
module dacc_top
  import dacc_pkg::*;
#(
  parameter int STARTUP_CYCLES = DACC_STARTUP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] sleep_mode,
  input wire logic debug_halt,
  output logic conv_power,
  output logic buffer_power,
  output logic internal_out_valid,
  output logic [7:0] conv_code,
  output logic conv_start
);
  import dacc_pkg::*;

  // ****************************************
  // state record
  // ****************************************
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] data;
    logic pending;
    dacc_state_t fsm;
    logic [15:0] wait_cnt;
    logic [1:0] sleep_s1;
    logic [1:0] sleep_s2;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic conv_power;
    logic buffer_power;
    logic internal_out_valid;
    logic [7:0] conv_code;
    logic conv_start;
  } dacc_regs_t;

  // start-up length as loaded into the down-counter
  localparam logic [15:0] STARTUP_LOAD = 16'(STARTUP_CYCLES);
  localparam logic [15:0] CNT_ONE = 16'h0001;

  dacc_regs_t cur;
  dacc_regs_t next_cur;

  // address decode shared by read and write paths
  // unmapped offsets decode to zero and answer with pslverr
  function automatic logic [1:0] dacc_decode(input logic [11:0] a);
    if (a == DACC_CTRL_ADDR) begin
      return 2'b01;
    end else if (a == DACC_DATA_ADDR) begin
      return 2'b10;
    end else begin
      return 2'b00;
    end
  endfunction

  logic access;
  logic [1:0] hit;
  logic wr_ctrl;
  logic wr_data;
  logic en_bit;
  logic sleep_off;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_cur = cur;
    // the cycle after pready rises is not a second access
    access = psel && penable && !cur.pready;
    hit = dacc_decode(paddr);
    wr_ctrl = access && pwrite && hit[0] && pstrb[0];
    wr_data = access && pwrite && hit[1] && pstrb[0];
    // sleep sampled through two flops, the mode pin is asynchronous
    // debug_halt read nowhere: a halt changes nothing, see RULE12
    next_cur.sleep_s1 = sleep_mode;
    next_cur.sleep_s2 = cur.sleep_s1;
    // apb: one wait state, answer on second access cycle
    next_cur.pready = access;
    next_cur.pslverr = access && (hit == 2'b00);
    next_cur.prdata = DACC_ZERO_WORD;
    if (access && !pwrite) begin
      if (hit[0]) begin
        next_cur.prdata = {24'h00_0000, cur.ctrl}; // see RULE13
      end else if (hit[1]) begin
        next_cur.prdata = {24'h00_0000, cur.data}; // see RULE10
      end
    end
    // register writes, reserved bits masked
    if (wr_ctrl) begin
      next_cur.ctrl = pwdata[7:0] & DACC_CTRL_MASK; // see RULE13
    end
    if (wr_data) begin
      next_cur.data = pwdata[7:0]; // see RULE10
    end
    // decisions use the enable value as it stands after this edge
    en_bit = next_cur.ctrl[DACC_ENABLE_BIT];
    // sleep gating: power-down always, standby unless run-in-standby
    sleep_off = (cur.sleep_s2 == DACC_SLEEP_PDOWN) || // see RULE9
      (cur.sleep_s2 == DACC_SLEEP_STANDBY &&
       !cur.ctrl[DACC_RUN_IN_STANDBY_BIT]); // see RULE6 RULE7
    // conversion requests: data write while on, or enable edge
    if (wr_data && cur.ctrl[DACC_ENABLE_BIT]) begin
      next_cur.pending = 1'b1; // see RULE2
    end
    if (wr_ctrl && en_bit && !cur.ctrl[DACC_ENABLE_BIT]) begin
      next_cur.pending = 1'b1; // see RULE3
    end
    // conv_start is a one-cycle pulse, low unless reissued below;
    // power sequencing runs off, counted start-up, then run, and a
    // conversion is only issued from the run state
    next_cur.conv_start = 1'b0;
    case (cur.fsm)
      DACC_OFF: begin
        if (en_bit && !sleep_off) begin
          next_cur.fsm = DACC_START; // see RULE1 RULE8
          next_cur.wait_cnt = STARTUP_LOAD;
        end
      end
      DACC_START: begin
        if (!en_bit || sleep_off) begin
          next_cur.fsm = DACC_OFF;
        end else if (cur.wait_cnt <= CNT_ONE) begin
          next_cur.fsm = DACC_RUN; // see RULE8
        end else begin
          next_cur.wait_cnt = cur.wait_cnt - CNT_ONE;
        end
      end
      DACC_RUN: begin
        if (!en_bit) begin
          next_cur.fsm = DACC_OFF; // see RULE1
        end else if (sleep_off) begin
          next_cur.fsm = DACC_OFF; // see RULE7
          // keep the code queued so it converts again after wake-up
          next_cur.pending = 1'b1; // see RULE8
        end else if (cur.pending) begin
          next_cur.conv_code = cur.data; // see RULE2
          next_cur.conv_start = 1'b1;
          next_cur.pending = wr_data;
        end
      end
      default: begin
        next_cur.fsm = DACC_OFF;
      end
    endcase
    // disabling drops a queued request so it cannot fire on re-enable
    if (!en_bit) begin
      next_cur.pending = wr_ctrl ? 1'b0 :
        cur.pending && !cur.ctrl[DACC_ENABLE_BIT];
    end
    // analog power and routing
    next_cur.conv_power = (next_cur.fsm != DACC_OFF); // see RULE1
    next_cur.internal_out_valid = (next_cur.fsm == DACC_RUN); // see RULE5
    next_cur.buffer_power = (next_cur.fsm != DACC_OFF) &&
      next_cur.ctrl[DACC_OUTPUT_BUFFER_ENABLE_BIT]; // see RULE4
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '{ctrl: DACC_CTRL_RESET, data: DACC_DATA_RESET,
               fsm: DACC_OFF, default: '0};
    end else if (clk_en) begin
      // clk_en low holds every field, bus answer included
      cur <= next_cur;
    end
  end

  // outputs straight from flops
  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign conv_power = cur.conv_power;
  assign buffer_power = cur.buffer_power;
  assign internal_out_valid = cur.internal_out_valid;
  assign conv_code = cur.conv_code;
  assign conv_start = cur.conv_start;

  // ****************************************
  // assertions
  // ****************************************
  // every property samples on the bus clock and is muted in reset;
  // clk_en appears in the antecedent wherever state must advance,
  // since a frozen cycle legally repeats the previous outputs
  // outputs are registered, so an effect decided at one edge is
  // visible at the next sample: most checks therefore use |=>
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_buffer_needs_conv: assert property ( // see RULE4
    buffer_power |-> conv_power)
    else $error("buffer powered without converter");
  a_pdown_powers_off: assert property ( // see RULE9
    clk_en && cur.sleep_s2 == DACC_SLEEP_PDOWN
    |=> !conv_power && !buffer_power)
    else $error("converter on in power-down");
  a_reserved_zero: assert property ( // see RULE13
    (cur.ctrl & ~DACC_CTRL_MASK) == 8'h00)
    else $error("reserved control bits set");
  a_start_needs_run: assert property ( // see RULE2
    conv_start |-> internal_out_valid && conv_code == $past(cur.data))
    else $error("conversion outside run state");
  a_data_write_stores: assert property ( // see RULE10
    clk_en && wr_data |=> cur.data == $past(pwdata[7:0]))
    else $error("data write not stored");
  a_disable_powers_off: assert property ( // see RULE1
    clk_en && !next_cur.ctrl[DACC_ENABLE_BIT] |=> !conv_power)
    else $error("converter on while disabled");
  a_standby_off: assert property ( // see RULE7
    clk_en && sleep_off |=> !internal_out_valid)
    else $error("running in standby without run-in-standby");
  a_ready_one_wait: assert property ( // see RULE10
    clk_en && psel && !penable ##1 clk_en && psel && penable [*2]
    |-> pready)
    else $error("apb answer late");

  // ****************************************
  // further checks, grouped by rule
  // ****************************************
  // enable written with no sleep request must power the converter
  a_enable_powers_on: assert property ( // see RULE1
    clk_en && en_bit && !sleep_off |=> conv_power)
    else $error("converter off while enabled");

  // control writes keep only the implemented bits
  a_ctrl_write_stores: assert property ( // see RULE1
    clk_en && wr_ctrl |=>
    cur.ctrl == ($past(pwdata[7:0]) & DACC_CTRL_MASK))
    else $error("control write not stored");

  // power state register never holds two states at once
  a_state_onehot: assert property ( // see RULE1
    $onehot(cur.fsm))
    else $error("power state not one-hot");

  // a data write while running yields a pulse two edges later
  a_write_converts: assert property ( // see RULE2
    clk_en && wr_data && cur.fsm == DACC_RUN && en_bit && !sleep_off
    ##1 clk_en && en_bit && !sleep_off
    |=> conv_start && conv_code == $past(pwdata[7:0], 2))
    else $error("data write did not convert");

  // with the enable bit clear nothing may start a conversion
  a_start_needs_enable: assert property ( // see RULE3
    conv_start |-> cur.ctrl[DACC_ENABLE_BIT])
    else $error("conversion while disabled");

  // setting the enable bit arms one conversion of the stored code
  a_enable_arms: assert property ( // see RULE3
    clk_en && wr_ctrl && en_bit && !cur.ctrl[DACC_ENABLE_BIT]
    |=> cur.pending)
    else $error("enable did not arm a conversion");

  // the pin buffer follows the converter and the output enable bit
  a_buffer_follows_output_buffer_enable: assert property ( // see RULE4
    buffer_power == (conv_power && cur.ctrl[DACC_OUTPUT_BUFFER_ENABLE_BIT]))
    else $error("pin buffer mismatch");

  // internal consumers see the output whenever it runs
  a_internal_when_run: assert property ( // see RULE5
    internal_out_valid == (conv_power && cur.fsm == DACC_RUN))
    else $error("internal output mismatch");

  // run-in-standby keeps a running converter alive in standby
  a_standby_kept: assert property ( // see RULE6
    clk_en && cur.fsm == DACC_RUN && en_bit &&
    cur.ctrl[DACC_RUN_IN_STANDBY_BIT] && cur.sleep_s2 == DACC_SLEEP_STANDBY
    |=> internal_out_valid)
    else $error("standby stopped converter");

  // stopping for sleep keeps the code queued for after wake-up
  a_sleep_requeues: assert property ( // see RULE8
    clk_en && cur.fsm == DACC_RUN && en_bit && sleep_off
    |=> cur.pending && !conv_power)
    else $error("sleep lost the queued conversion");

  // leaving off always reloads the full start-up count
  a_startup_load: assert property ( // see RULE8
    clk_en && cur.fsm == DACC_OFF && en_bit && !sleep_off
    |=> cur.fsm == DACC_START && cur.wait_cnt == STARTUP_LOAD)
    else $error("start-up count not loaded");

  // the start-up count steps down by one per enabled cycle
  a_startup_counts: assert property ( // see RULE8
    clk_en && cur.fsm == DACC_START && en_bit && !sleep_off &&
    cur.wait_cnt > CNT_ONE
    |=> cur.fsm == DACC_START &&
    cur.wait_cnt == $past(cur.wait_cnt) - CNT_ONE)
    else $error("start-up count skipped");

  // no conversion is issued before start-up has run out
  a_start_after_wait: assert property ( // see RULE8
    conv_start |-> cur.fsm == DACC_RUN)
    else $error("conversion during start-up");

  // data only changes through an accepted write with lane 0 set
  a_data_holds: assert property ( // see RULE10
    clk_en && !wr_data |=> cur.data == $past(cur.data))
    else $error("data changed without a write");

  // each answer is a single-cycle pulse
  a_ready_pulse: assert property ( // see RULE10
    clk_en && pready |=> !pready)
    else $error("ready held too long");

  // an unmapped access reads zero and flags the error with ready
  a_error_reads_zero: assert property ( // see RULE10
    pslverr |-> pready && prdata == DACC_ZERO_WORD)
    else $error("error answer carries data");

  // main scenarios the bench is expected to reach
  c_convert: cover property (conv_start);
  c_buffer_on: cover property (buffer_power);
  c_startup_done: cover property (cur.fsm == DACC_START ##1
    cur.fsm == DACC_RUN);
  c_bus_error: cover property (pslverr);
  c_standby_kept: cover property (cur.sleep_s2 == DACC_SLEEP_STANDBY &&
    internal_out_valid);
endmodule

// *** tb/tb_dacc_top.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ns
module tb;
  import dacc_pkg::*;
  // ****************************************
  // stimulus, outputs and expectation queues
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic debug_halt = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [1:0] sleep_mode = DACC_SLEEP_ACTIVE;
  logic [31:0] prdata;
  logic pready, pslverr, conv_power, buffer_power, iov, conv_start;
  logic [7:0] conv_code;
  logic [7:0] v;
  logic [32:0] rq[$];
  logic [32:0] cq[$];
  logic [32:0] note;
  logic [7:0] sc[4] = '{8'h41, 8'hc1, 8'hc1, 8'h41};
  logic [1:0] sm[4] = '{DACC_SLEEP_STANDBY, DACC_SLEEP_STANDBY,
                        DACC_SLEEP_PDOWN, DACC_SLEEP_IDLE};
  logic on[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  int n_fail = 0;
  int checks_done = 0;
  // clock of 40 ns
  always #20 pclk = ~pclk;
  dacc_top #(.STARTUP_CYCLES(2)) dut (.pclk(pclk), .presetn(presetn),
    .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
    .debug_halt(debug_halt), .conv_power(conv_power),
    .buffer_power(buffer_power), .internal_out_valid(iov),
    .conv_code(conv_code), .conv_start(conv_start));
  // ****************************************
  // compare, verdict and bus tasks
  // ****************************************
  task automatic chk(input logic [32:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic timed_out();
    n_fail++;
    $display("ERROR wait expected done seen timeout");
    final_report();
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) timed_out();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] exp);
    rq.push_back(exp);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d}, 4'hf);
  endtask
  // wait until every noted conversion has appeared
  task automatic drain();
    int i;
    for (i = 0; i < 100 && cq.size() != 0; i++) @(posedge pclk);
    if (cq.size() != 0) timed_out();
    repeat (2) @(posedge pclk);
  endtask
  // ****************************************
  // monitor: oldest note against each result
  // ****************************************
  always @(posedge pclk) begin
    if (pready === 1'b1 && pwrite === 1'b0) begin
      note = rq.size() ? rq.pop_front() : 33'h1_ffff_ffff;
      chk({pslverr, prdata}, note, "read word");
    end
    if (conv_start === 1'b1) begin
      note = cq.size() ? cq.pop_front() : 33'h1_0000_0000;
      chk({25'h0, conv_code}, note, "converted code");
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(79827));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(DACC_CTRL_ADDR, 33'h0_0000_0000);
    rd(DACC_DATA_ADDR, 33'h0_0000_0000);
    rd(12'h008, 33'h1_0000_0000);
    wr(DACC_CTRL_ADDR, 8'hbe);
    rd(DACC_CTRL_ADDR, 33'h0_0000_0080);
    // only stored while disabled; a write with lane 0 off is dropped
    v = 8'($urandom);
    wr(DACC_DATA_ADDR, v);
    apb(1'b1, DACC_DATA_ADDR, {24'h00_0000, ~v}, 4'he);
    rd(DACC_DATA_ADDR, {25'h0, v});
    chk(conv_power, 1'b0, "power while disabled");
    // enabling converts the stored code
    cq.push_back({25'h0, v});
    wr(DACC_CTRL_ADDR, 8'h41);
    drain();
    chk(buffer_power, 1'b1, "pin buffer");
    // back-to-back data writes, debug halt toggling meanwhile
    for (int k = 0; k < 4; k++) begin
      v = 8'($urandom);
      debug_halt <= 1'($urandom);
      cq.push_back({25'h0, v});
      wr(DACC_DATA_ADDR, v);
    end
    drain();
    wr(DACC_CTRL_ADDR, 8'h01);
    repeat (3) @(posedge pclk);
    chk(buffer_power, 1'b0, "buffer off");
    chk(iov, 1'b1, "internal output");
    // sleep modes, each followed by a wake-up
    for (int k = 0; k < 4; k++) begin
      wr(DACC_CTRL_ADDR, sc[k]);
      sleep_mode <= sm[k];
      repeat (6) @(posedge pclk);
      chk(conv_power, on[k], "power in sleep");
      chk(buffer_power, on[k], "buffer in sleep");
      if (!on[k]) cq.push_back({25'h0, v});
      sleep_mode <= DACC_SLEEP_ACTIVE;
      drain();
      chk(buffer_power, 1'b1, "buffer after wake");
    end
    wr(DACC_CTRL_ADDR, 8'h00);
    repeat (3) @(posedge pclk);
    chk(conv_power, 1'b0, "power after disable");
    chk(iov, 1'b0, "internal output off");
    rd(DACC_DATA_ADDR, {25'h0, v});
    repeat (4) @(posedge pclk);
    chk(33'(rq.size()), 33'h0, "unanswered reads");
    chk(33'(cq.size()), 33'h0, "missing conversions");
    final_report();
  end
endmodule
